// file: hw/accum_mode_pkg.sv
package accum_mode_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [15:0] IDX_ACCUM_MODE = 16'he701;
  localparam logic [15:0] IDX_LINE_CYCLE = 16'he702;
  localparam logic [15:0] IDX_SAG_LEVEL = 16'he710;
  localparam logic [15:0] IDX_STATUS = 16'he711;
  localparam logic [15:0] IDX_TERM_SEL = 16'he712;
  localparam logic [15:0] IDX_B_VRMS = 16'he713;
  localparam logic [15:0] IDX_VAR_TOT_A = 16'he714;
  localparam logic [15:0] IDX_VAR_TOT_B = 16'he715;
  localparam logic [15:0] IDX_VAR_TOT_C = 16'he716;
  localparam logic [15:0] IDX_VAR_FUND_A = 16'he717;
  localparam logic [15:0] IDX_VAR_FUND_B = 16'he718;
  localparam logic [15:0] IDX_VAR_FUND_C = 16'he719;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] ACCUM_MODE_RST = 8'h80;
  localparam logic [7:0] LINE_CYCLE_RST = 8'h78;
  localparam logic [31:0] SAG_LEVEL_RST = 32'h0000_0000;
  localparam logic [8:0] TERM_SEL_RST = 9'h1ff;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int VAR_MODE_LSB = 2;
  localparam int WIRING_LSB = 4;
  localparam int SAG_CFG_BIT = 6;
  localparam int STATUS_SAG_BIT = 0;

  // ==========================================================
  // Encodings
  // ==========================================================
  typedef enum logic [1:0] {
    VAR_SIGNED = 2'b00,
    VAR_RESERVED = 2'b01,
    VAR_BY_ACTIVE_SIGN = 2'b10,
    VAR_ABSOLUTE = 2'b11
  } var_mode_t;

  typedef enum logic [1:0] {
    WIRE_4W_WYE = 2'b00,
    WIRE_3W_DELTA = 2'b01,
    WIRE_RESERVED = 2'b10,
    WIRE_4W_DELTA = 2'b11
  } wiring_t;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// file: hw/energy_accumulation_mode_config.sv
`timescale 1ns/1ps
// How it works
// - Reactive mode code 01 behaves exactly like signed code 00.
// - Code 10 adds reactive power, sign-flipped when matching active power is negative.
// - Code 11 accumulates reactive power magnitude in registers and pulses.
// - Code 00 accumulates signed reactive power, registers and pulses alike.
// - Wiring field bits 5:4 picks accumulator inputs; reactive uses -90 degree currents.
// - Wiring codes: 00 wye four-wire, 01 three-wire delta, 11 four-wire delta.
// - Phases A, C own inputs; phase B voltage is VB, VA-VC or -VA.
// - Three-wire mode puts rms of line voltage A-C in phase B rms result.
// - Three-wire mode forces filtered phase B current to zero.
// - Sag config 0 sets sag flag while any phase voltage is below threshold.
// - Sag config 1 sets sag flag when a voltage dips below then recovers.
// - Mode register bit 7 resets to one and controls nothing.
module energy_accumulation_mode_config
  import accum_mode_pkg::*;
#(
  parameter int W = 16,
  parameter int EW = 48,
  parameter int RMS_LOG2 = 8,
  parameter int AW = 20,
  parameter logic [EW-1:0] PULSE_THRESHOLD = 48'h0000_1000_0000
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic signed [W-1:0] va,
  input wire logic signed [W-1:0] vb,
  input wire logic signed [W-1:0] vc,
  input wire logic signed [W-1:0] ia,
  input wire logic signed [W-1:0] ib,
  input wire logic signed [W-1:0] ic,
  input wire logic signed [W-1:0] ia_q,
  input wire logic signed [W-1:0] ib_q,
  input wire logic signed [W-1:0] ic_q,
  input wire logic fund_valid,
  input wire logic signed [2*W:0] fund_active_a,
  input wire logic signed [2*W:0] fund_active_b,
  input wire logic signed [2*W:0] fund_active_c,
  input wire logic signed [2*W:0] fund_reactive_a,
  input wire logic signed [2*W:0] fund_reactive_b,
  input wire logic signed [2*W:0] fund_reactive_c,
  input wire logic rms_valid,
  input wire logic [W-1:0] vrms_a,
  input wire logic [W-1:0] vrms_b,
  input wire logic [W-1:0] vrms_c,
  output logic [2:0] energy_pulse_output,
  output logic [W:0] phase_b_voltage_rms_result,
  output logic sag_flag
);

  localparam int PW = 2*W+1;

  // ==========================================================
  // Register state
  // ==========================================================
  logic [7:0] accumulation_mode_control_reg;
  logic [7:0] line_cycle_mode_control_reg;
  logic [31:0] sag_threshold_level_reg;
  logic [8:0] term_sel_reg;
  logic [31:0] second_status_register_reg;
  logic signed [EW-1:0] var_tot_reg [3];
  logic signed [EW-1:0] var_fund_reg [3];
  logic signed [EW-1:0] pulse_acc_reg [3];
  logic pulse_reg [3];

  // Bit 7 is stored and read back only
  wire [1:0] reactive_accum_mode = accumulation_mode_control_reg[VAR_MODE_LSB +: 2];
  wire [1:0] wiring_connection_select = accumulation_mode_control_reg[WIRING_LSB +: 2];
  wire sag_flag_config = accumulation_mode_control_reg[SAG_CFG_BIT];
  wire three_wire = (wiring_connection_select == WIRE_3W_DELTA);

  // ==========================================================
  // Reactive sign handling
  // ==========================================================
  function automatic logic signed [PW-1:0] var_term(input logic signed [PW-1:0] q,
                                                    input logic signed [PW-1:0] p,
                                                    input logic [1:0] mode);
    logic neg;
    neg = 1'b0;
    if (mode == VAR_BY_ACTIVE_SIGN) begin
      neg = p[PW-1];
    end else if (mode == VAR_ABSOLUTE) begin
      neg = q[PW-1];
    end
    // Codes 00 and 01 both keep the sign
    var_term = neg ? -q : q;
  endfunction

  function automatic logic [31:0] merge_strobe(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    merge_strobe = res;
  endfunction

  // ==========================================================
  // Phase powers
  // ==========================================================
  logic power_valid;
  logic signed [PW-1:0] p_a, p_b, p_c, q_a, q_b, q_c;

  phase_power_calc #(.W(W)) u_power (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sample_valid(sample_valid),
    .wiring_connection_select(wiring_connection_select),
    .va(va),
    .vb(vb),
    .vc(vc),
    .ia(ia),
    .ib(ib),
    .ic(ic),
    .ia_q(ia_q),
    .ib_q(ib_q),
    .ic_q(ic_q),
    .power_valid(power_valid),
    .p_a(p_a),
    .p_b(p_b),
    .p_c(p_c),
    .q_a(q_a),
    .q_b(q_b),
    .q_c(q_c)
  );

  wire signed [PW-1:0] tot_term [3];
  wire signed [PW-1:0] fund_term [3];
  assign tot_term[0] = var_term(q_a, p_a, reactive_accum_mode);
  assign tot_term[1] = var_term(q_b, p_b, reactive_accum_mode);
  assign tot_term[2] = var_term(q_c, p_c, reactive_accum_mode);
  assign fund_term[0] = var_term(fund_reactive_a, fund_active_a, reactive_accum_mode);
  assign fund_term[1] = var_term(fund_reactive_b, fund_active_b, reactive_accum_mode);
  assign fund_term[2] = var_term(fund_reactive_c, fund_active_c, reactive_accum_mode);

  // ==========================================================
  // Energy accumulators and pulse converters
  // ==========================================================
  // Each converter sums the phases its three term-select bits enable; phase B
  // is left in unless software clears its bit in three-wire mode
  wire signed [EW-1:0] pulse_sum [3];
  for (genvar k = 0; k < 3; k++) begin : g_conv
    assign pulse_sum[k] = (term_sel_reg[3*k] ? EW'(tot_term[0]) : '0)
                        + (term_sel_reg[3*k+1] ? EW'(tot_term[1]) : '0)
                        + (term_sel_reg[3*k+2] ? EW'(tot_term[2]) : '0);
    wire signed [EW-1:0] acc_new = pulse_acc_reg[k] + pulse_sum[k];
    wire pos_hit = (acc_new >= $signed(PULSE_THRESHOLD));
    wire neg_hit = (acc_new <= -$signed(PULSE_THRESHOLD));

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        var_tot_reg[k] <= '0;
        var_fund_reg[k] <= '0;
        pulse_acc_reg[k] <= '0;
        pulse_reg[k] <= 1'b0;
      end else begin
        pulse_reg[k] <= 1'b0;
        if (power_valid) begin
          var_tot_reg[k] <= var_tot_reg[k] + EW'(tot_term[k]);
          // Pulses use the same mode-adjusted terms as the registers
          pulse_reg[k] <= pos_hit | neg_hit;
          pulse_acc_reg[k] <= pos_hit ? acc_new - $signed(PULSE_THRESHOLD)
                            : (neg_hit ? acc_new + $signed(PULSE_THRESHOLD) : acc_new);
        end
        if (fund_valid) begin
          var_fund_reg[k] <= var_fund_reg[k] + EW'(fund_term[k]);
        end
      end
    end
  end

  assign energy_pulse_output = {pulse_reg[2], pulse_reg[1], pulse_reg[0]};

  // ==========================================================
  // Line-voltage rms for three-wire wiring
  // ==========================================================
  // Mean square over a block of samples, then a bit-serial square root;
  // the result lags the block by W+1 cycles, trading speed for area
  localparam int SQW = 2*W+2;
  localparam int SUMW = SQW + RMS_LOG2;
  wire signed [W:0] line_ac = {va[W-1], va} - {vc[W-1], vc};
  wire [SQW-1:0] line_sq = SQW'(line_ac * line_ac);
  logic [SUMW-1:0] sq_sum_reg;
  logic [RMS_LOG2-1:0] sq_cnt_reg;
  logic [SQW-1:0] mean_reg;
  logic [W:0] root_reg;
  logic [5:0] root_bit_reg;
  logic root_busy_reg;
  logic [W:0] rms_ac_reg;
  wire [W:0] trial = root_reg | ((W+1)'(1) << root_bit_reg);
  wire [SQW-1:0] trial_sq = SQW'(trial * trial);
  wire block_done = sample_valid && (sq_cnt_reg == '1);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sq_sum_reg <= '0;
      sq_cnt_reg <= '0;
      mean_reg <= '0;
      root_reg <= '0;
      root_bit_reg <= '0;
      root_busy_reg <= 1'b0;
      rms_ac_reg <= '0;
    end else begin
      if (sample_valid) begin
        sq_cnt_reg <= sq_cnt_reg + 1'b1;
        sq_sum_reg <= block_done ? '0 : sq_sum_reg + SUMW'(line_sq);
      end
      if (block_done) begin
        mean_reg <= SQW'((sq_sum_reg + SUMW'(line_sq)) >> RMS_LOG2);
        root_reg <= '0;
        root_bit_reg <= 6'(W);
        root_busy_reg <= 1'b1;
      end else if (root_busy_reg) begin
        if (trial_sq <= mean_reg) begin
          root_reg <= trial;
        end
        if (root_bit_reg == '0) begin
          root_busy_reg <= 1'b0;
          rms_ac_reg <= (trial_sq <= mean_reg) ? trial : root_reg;
        end else begin
          root_bit_reg <= root_bit_reg - 1'b1;
        end
      end
    end
  end

  wire [W:0] vrms_b_eff = three_wire ? rms_ac_reg : {1'b0, vrms_b};
  // Output leaves a flip-flop, so it follows a wiring change one cycle later
  logic [W:0] b_rms_out_reg;

  // ==========================================================
  // Sag detection
  // ==========================================================
  wire [W:0] sag_lvl = sag_threshold_level_reg[W:0];
  wire [2:0] below = {{1'b0, vrms_c} < sag_lvl, vrms_b_eff < sag_lvl, {1'b0, vrms_a} < sag_lvl};
  logic [2:0] dipped_reg;
  wire [2:0] recovered = dipped_reg & ~below;
  wire sag_event = rms_valid && (sag_flag_config ? |recovered : |below);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dipped_reg <= '0;
      b_rms_out_reg <= '0;
    end else begin
      b_rms_out_reg <= vrms_b_eff;
      if (rms_valid) begin
        dipped_reg <= below;
      end
    end
  end

  assign phase_b_voltage_rms_result = b_rms_out_reg;

  assign sag_flag = second_status_register_reg[STATUS_SAG_BIT];

  // ==========================================================
  // AXI4-Lite slave
  // ==========================================================
  logic aw_held_reg, w_held_reg;
  logic [AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  function automatic logic [15:0] reg_index(input logic [AW-1:0] addr);
    reg_index = 16'(addr >> 2);
  endfunction

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_held_reg || aw_fire;
  wire have_w = w_held_reg || w_fire;
  wire do_write = have_aw && have_w && !s_axi_bvalid;
  wire [AW-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire [15:0] wr_idx = reg_index(wr_addr);
  wire wr_aligned = (wr_addr[1:0] == 2'b00);
  wire wr_mode = do_write && wr_aligned && (wr_idx == IDX_ACCUM_MODE);
  wire wr_line = do_write && wr_aligned && (wr_idx == IDX_LINE_CYCLE);
  wire wr_sag = do_write && wr_aligned && (wr_idx == IDX_SAG_LEVEL);
  wire wr_stat = do_write && wr_aligned && (wr_idx == IDX_STATUS);
  wire wr_term = do_write && wr_aligned && (wr_idx == IDX_TERM_SEL);
  // Read-only registers accept writes with no effect
  wire wr_ro = do_write && wr_aligned && (wr_idx >= IDX_B_VRMS) && (wr_idx <= IDX_VAR_FUND_C);
  wire wr_hit = wr_mode | wr_line | wr_sag | wr_stat | wr_term | wr_ro;
  wire [31:0] clr_mask = wr_stat ? merge_strobe(32'h0000_0000, wr_data, wr_strb) : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      accumulation_mode_control_reg <= ACCUM_MODE_RST;
      line_cycle_mode_control_reg <= LINE_CYCLE_RST;
      sag_threshold_level_reg <= SAG_LEVEL_RST;
      term_sel_reg <= TERM_SEL_RST;
      second_status_register_reg <= '0;
    end else begin
      if (aw_fire && !do_write) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_fire && !do_write) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_mode && wr_strb[0]) begin
        accumulation_mode_control_reg <= wr_data[7:0];
      end
      if (wr_line && wr_strb[0]) begin
        line_cycle_mode_control_reg <= wr_data[7:0];
      end
      if (wr_sag) begin
        sag_threshold_level_reg <= merge_strobe(sag_threshold_level_reg, wr_data, wr_strb);
      end
      if (wr_term) begin
        term_sel_reg <= 9'(merge_strobe({23'h000000, term_sel_reg}, wr_data, wr_strb));
      end
      // Write-one-to-clear; a sag in the same cycle wins over the clear
      second_status_register_reg[STATUS_SAG_BIT] <=
        sag_event | (second_status_register_reg[STATUS_SAG_BIT] & ~clr_mask[STATUS_SAG_BIT]);
    end
  end

  wire [15:0] rd_idx = reg_index(s_axi_araddr);
  wire rd_ok = (s_axi_araddr[1:0] == 2'b00);
  wire [31:0] rd_data =
      !rd_ok ? 32'h0000_0000
    : (rd_idx == IDX_ACCUM_MODE) ? {24'h000000, accumulation_mode_control_reg}
    : (rd_idx == IDX_LINE_CYCLE) ? {24'h000000, line_cycle_mode_control_reg}
    : (rd_idx == IDX_SAG_LEVEL) ? sag_threshold_level_reg
    : (rd_idx == IDX_STATUS) ? second_status_register_reg
    : (rd_idx == IDX_TERM_SEL) ? {23'h000000, term_sel_reg}
    : (rd_idx == IDX_B_VRMS) ? 32'(vrms_b_eff)
    : (rd_idx == IDX_VAR_TOT_A) ? var_tot_reg[0][31:0]
    : (rd_idx == IDX_VAR_TOT_B) ? var_tot_reg[1][31:0]
    : (rd_idx == IDX_VAR_TOT_C) ? var_tot_reg[2][31:0]
    : (rd_idx == IDX_VAR_FUND_A) ? var_fund_reg[0][31:0]
    : (rd_idx == IDX_VAR_FUND_B) ? var_fund_reg[1][31:0]
    : (rd_idx == IDX_VAR_FUND_C) ? var_fund_reg[2][31:0]
    : 32'h0000_0000;
  wire rd_hit = rd_ok && (rd_idx == IDX_ACCUM_MODE || rd_idx == IDX_LINE_CYCLE ||
                          (rd_idx >= IDX_SAG_LEVEL && rd_idx <= IDX_VAR_FUND_C));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: hw/phase_power_calc.sv
`timescale 1ns/1ps
module phase_power_calc
  import accum_mode_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sample_valid,
  input wire logic [1:0] wiring_connection_select,
  input wire logic signed [W-1:0] va,
  input wire logic signed [W-1:0] vb,
  input wire logic signed [W-1:0] vc,
  input wire logic signed [W-1:0] ia,
  input wire logic signed [W-1:0] ib,
  input wire logic signed [W-1:0] ic,
  input wire logic signed [W-1:0] ia_q,
  input wire logic signed [W-1:0] ib_q,
  input wire logic signed [W-1:0] ic_q,
  output logic power_valid,
  output logic signed [2*W:0] p_a,
  output logic signed [2*W:0] p_b,
  output logic signed [2*W:0] p_c,
  output logic signed [2*W:0] q_a,
  output logic signed [2*W:0] q_b,
  output logic signed [2*W:0] q_c
);

  // ==========================================================
  // Phase B substitutions
  // ==========================================================
  wire three_wire = (wiring_connection_select == WIRE_3W_DELTA);
  wire four_delta = (wiring_connection_select == WIRE_4W_DELTA);
  wire signed [W:0] va_x = {va[W-1], va};
  wire signed [W:0] vc_x = {vc[W-1], vc};
  wire signed [W:0] vb_x = {vb[W-1], vb};
  // Reserved code falls back to own phase B voltage
  wire signed [W:0] vb_sel = three_wire ? va_x - vc_x : (four_delta ? -va_x : vb_x);
  // Filtered phase B current is zero in three-wire so p_b and q_b are both zero
  wire signed [W-1:0] ib_sel = three_wire ? '0 : ib;
  wire signed [W-1:0] ibq_sel = three_wire ? '0 : ib_q;

  // ==========================================================
  // Products, registered once per sample
  // ==========================================================
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      power_valid <= 1'b0;
      p_a <= '0;
      p_b <= '0;
      p_c <= '0;
      q_a <= '0;
      q_b <= '0;
      q_c <= '0;
    end else begin
      power_valid <= sample_valid;
      if (sample_valid) begin
        p_a <= (2*W+1)'(va * ia);
        p_c <= (2*W+1)'(vc * ic);
        p_b <= (2*W+1)'(vb_sel * ib_sel);
        q_a <= (2*W+1)'(va * ia_q);
        q_c <= (2*W+1)'(vc * ic_q);
        q_b <= (2*W+1)'(vb_sel * ibq_sel);
      end
    end
  end

endmodule

// file: test/energy_accumulation_mode_config_properties.sv
`timescale 1ns/1ps
// ====================
// Port-level checks
module energy_accumulation_mode_config_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic rms_valid,
  input wire logic [2:0] energy_pulse_output,
  input wire logic sag_flag
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  property p_b_after_write;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_b_after_write: assert property (p_b_after_write) else $error("write response missing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_after_read;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after_read: assert property (p_r_after_read) else $error("read response missing");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_busy_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("write taken while busy");
  // Flag may only rise as a result of a new rms result
  property p_sag_cause;
    $rose(sag_flag) |-> $past(rms_valid) || $past(rms_valid, 2);
  endproperty
  a_sag_cause: assert property (p_sag_cause) else $error("sag flag without rms");
  property p_sag_clear;
    $fell(sag_flag) |-> s_axi_bvalid;
  endproperty
  a_sag_clear: assert property (p_sag_clear) else $error("sag flag lost");
  property p_pulse_cause;
    |energy_pulse_output |-> $past(sample_valid, 2) || $past(sample_valid, 3);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without sample");
endmodule
bind energy_accumulation_mode_config energy_accumulation_mode_config_checker u_checker (.*);

// file: test/tb_energy_accumulation_mode_config.sv
`timescale 1ns/1ps
module tb_energy_accumulation_mode_config;
  import accum_mode_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [19:0] s_axi_awaddr = 20'h0, s_axi_araddr = 20'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sag_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic sample_valid = 1'b0, fund_valid = 1'b0, rms_valid = 1'b0;
  logic signed [15:0] va = 16'h0064, vb = 16'h0007, vc = 16'h0003, ia = 16'hfffb, ib = 16'h0002, ic = 16'h0004;
  logic signed [15:0] ia_q = 16'hfffd, ib_q = 16'h0005, ic_q = 16'h0006;
  logic signed [32:0] fund_active_a = 33'h1ffffffff, fund_active_b = 33'h1, fund_active_c = 33'h2;
  logic signed [32:0] fund_reactive_a = 33'h1ffffffd8, fund_reactive_b = 33'h9, fund_reactive_c = 33'hb;
  logic [15:0] vrms_a = 16'h07d0, vrms_b = 16'h07d0, vrms_c = 16'h07d0;
  logic [2:0] energy_pulse_output;
  logic [16:0] phase_b_voltage_rms_result;
  int error_cnt = 0;
  int samples_checked = 0;
  int pulse_cnt = 0;

  // All three converters select the same phases, so each pulse shows on all outputs at once
  always @(posedge ref_clk) if (energy_pulse_output == 3'b111) pulse_cnt <= pulse_cnt + 1;

  always #12.5 ref_clk = ~ref_clk;

  // Short window and threshold keep the rms and pulse paths inside a short run
  energy_accumulation_mode_config #(.RMS_LOG2(2), .PULSE_THRESHOLD(48'h100)) u_energy_accumulation_mode_config (.*);

  // ====================
  // Bus and check helpers
  task summarize;
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
      end
      n++;
    end while (n < 50 && (s_axi_awvalid || s_axi_wvalid || s_axi_bready));
    if (n == 50) begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic rc(input logic [15:0] idx, input logic [31:0] exp_d, input logic [1:0] exp_r, input string nm);
    int n;
    n = 0;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        chk(nm, s_axi_rdata, exp_d);
        chk(nm, {30'h0, s_axi_rresp}, {30'h0, exp_r});
      end
      n++;
    end while (n < 50 && (s_axi_arvalid || s_axi_rready));
    if (n == 50) begin
      error_cnt++;
      summarize();
    end
  endtask

  task smp;
    sample_valid <= 1'b1;
    fund_valid <= 1'b1;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    fund_valid <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask

  task rmsp(input logic [15:0] a);
    vrms_a <= a;
    rms_valid <= 1'b1;
    @(posedge ref_clk);
    rms_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // ====================
  // Scenarios
  task t_regs;
    rc(IDX_ACCUM_MODE, 32'h80, RESP_OKAY, "mode_reset");
    rc(IDX_LINE_CYCLE, 32'h78, RESP_OKAY, "line_cycle_reset");
    rc(16'h0100, 32'h0, RESP_SLVERR, "unmapped");
  endtask

  task t_sag;
    wr(IDX_ACCUM_MODE, 32'h80);
    wr(IDX_SAG_LEVEL, 32'h3e8);
    rmsp(16'h01f4);
    chk("sag_level", {31'h0, sag_flag}, 32'h1);
    rc(IDX_STATUS, 32'h1, RESP_OKAY, "status");
    wr(IDX_STATUS, 32'h1);
    chk("sag_cleared", {31'h0, sag_flag}, 32'h0);
    wr(IDX_ACCUM_MODE, 32'hc0);
    rmsp(16'h01f4);
    chk("sag_dip", {31'h0, sag_flag}, 32'h0);
    rmsp(16'h07d0);
    chk("sag_recover", {31'h0, sag_flag}, 32'h1);
    wr(IDX_STATUS, 32'h1);
  endtask

  // Phase A has negative active power, phase B flips sign only in four-wire delta
  task automatic t_energy;
    logic [7:0] m[8] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'hb0, 8'hb8, 8'h90, 8'ha0};
    int da[8] = '{-300, -300, 300, 300, -300, 300, -300, -300};
    int db[8] = '{35, 35, 35, 35, -500, 500, 0, 35};
    int ea = 0, eb = 0, ef = 0;
    for (int i = 0; i < 8; i++) begin
      wr(IDX_ACCUM_MODE, {24'h0, m[i]});
      smp();
      ea += da[i];
      eb += db[i];
      ef += da[i] / 300 * 40;
      rc(IDX_VAR_TOT_A, ea, RESP_OKAY, "total_a");
      rc(IDX_VAR_TOT_B, eb, RESP_OKAY, "total_b");
      rc(IDX_VAR_FUND_A, ef, RESP_OKAY, "fund_a");
    end
    chk("pulse_count", pulse_cnt, 32'h5);
  endtask

  task t_rms;
    wr(IDX_ACCUM_MODE, 32'h80);
    chk("b_rms_wye", {15'h0, phase_b_voltage_rms_result}, {16'h0, vrms_b});
    wr(IDX_ACCUM_MODE, 32'h90);
    wr(IDX_TERM_SEL, 32'h16d);
    rc(IDX_TERM_SEL, 32'h16d, RESP_OKAY, "term_sel");
    repeat (8) smp();
    repeat (40) @(posedge ref_clk);
    chk("b_rms_line", {15'h0, phase_b_voltage_rms_result}, 32'h61);
    rc(IDX_B_VRMS, 32'h61, RESP_OKAY, "b_rms_reg");
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_sag();
    t_energy();
    t_rms();
    summarize();
  end
endmodule
